//--- rtl/output_driver_power_short_ctrl.sv
// register bank for headphone and speaker driver power and short-circuit handling
//
// Operation
// R1 - headphone policy 0 and powerdown mode: short clears both headphone power bits
// R2 - speaker policy 0: short clears speaker power bit; policy 1 keeps it
// R3 - headphone bit 7 powers left headphone driver, resets to 0
// R4 - headphone bit 6 powers right headphone driver, resets to 0
// R5 - bits 4:3 select common mode 1.35, 1.5, 1.65, 1.8 V
// R6 - mode 0 only limits current on short; mode 1 powers driver down
// R7 - headphone bit 0 reads live headphone short status, resets to 0
// R8 - speaker bit 7 powers mono speaker driver, resets to 0
// R9 - speaker bit 0 reads speaker short, valid only while powered up
// R10 - speaker bits 5:1 reset to 00011; host writes back only that
// R11 - headphone bit 2 resets to 1; host writes only 1
// R12 - host writes only zero to headphone bit 5
// R13 - host never writes locations 1 through 29
// R14 - error control bits 7:2 and both policy bits reset to zero
// R15 - page registers answer only while page select holds one
// R16 - short detector inputs pass a two-flop synchroniser first
// R17 - automatic power bit clear beats a simultaneous host write
`timescale 1ns/10ps
`default_nettype none
module output_driver_power_short_ctrl (
  // clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            resetn_i,
  // register port
  input  wire logic                            reg_wr_i,
  input  wire logic [out_drv_pkg::ADDR_W-1:0]  reg_addr_i,
  input  wire logic [out_drv_pkg::DATA_W-1:0]  reg_wdata_i,
  output var  logic [out_drv_pkg::DATA_W-1:0]  reg_rdata_o,
  // short detectors, asynchronous
  input  wire logic                            hp_short_det_i,
  input  wire logic                            spk_short_det_i,
  // driver controls
  output var  logic                            left_headphone_driver_en_o,
  output var  logic                            right_headphone_driver_en_o,
  output var  out_drv_pkg::cm_sel_type         hp_cm_sel_o,
  output var  logic                            hp_current_limit_o,
  output var  logic                            spk_driver_en_o,
  output var  logic [out_drv_pkg::DATA_W-1:0]  page_sel_o
);
  import out_drv_pkg::*;

  logic [DATA_W-1:0] page_sel;
  logic              pol_hp;
  logic              pol_spk;
  logic [5:0]        pol_rsvd;
  logic              hp_left_pu;
  logic              hp_right_pu;
  logic              hp_rsvd5;
  logic [1:0]        hp_cm;
  logic              hp_rsvd2;
  logic              hp_mode;
  logic              spk_pu;
  logic              spk_rsvd6;
  logic [4:0]        spk_rsvd;

  logic [DATA_W-1:0] next_page_sel;
  logic              next_pol_hp;
  logic              next_pol_spk;
  logic [5:0]        next_pol_rsvd;
  logic              next_hp_left_pu;
  logic              next_hp_right_pu;
  logic              next_hp_rsvd5;
  logic [1:0]        next_hp_cm;
  logic              next_hp_rsvd2;
  logic              next_hp_mode;
  logic              next_spk_pu;
  logic              next_spk_rsvd6;
  logic [4:0]        next_spk_rsvd;
  logic [DATA_W-1:0] next_rdata;
  logic              next_left_en;
  logic              next_right_en;
  logic              next_limit;
  logic              next_spk_en;

  logic [1:0]        short_sync;
  logic              hp_short;
  logic              spk_short;
  logic              page_hit;
  logic              wr_pol;
  logic              wr_hp;
  logic              wr_spk;
  logic              hp_auto_clear;
  logic              spk_auto_clear;
  logic [DATA_W-1:0] pol_word;
  logic [DATA_W-1:0] hp_word;
  logic [DATA_W-1:0] spk_word;

  // detector levels enter the register clock domain here
  sync_two_ff #(
    .WIDTH (SYNC_W)
  ) u_short_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  ({hp_short_det_i, spk_short_det_i}),
    .sync_o   (short_sync)
  ); // R16

  assign hp_short  = short_sync[1];
  assign spk_short = short_sync[0];

  assign page_hit = (page_sel == PAGE_THIS); // R15
  assign wr_pol   = reg_wr_i && page_hit && (reg_addr_i == ADDR_AMP_ERR_POL);
  assign wr_hp    = reg_wr_i && page_hit && (reg_addr_i == ADDR_HP_DRV_CTRL);
  assign wr_spk   = reg_wr_i && page_hit && (reg_addr_i == ADDR_SPK_DRV_CTRL);

  // automatic power-down on short, per policy and mode
  assign hp_auto_clear  = hp_short && hp_mode && !pol_hp; // R1 R6
  assign spk_auto_clear = spk_short && !pol_spk; // R2

  assign pol_word = {pol_rsvd, pol_hp, pol_spk};
  assign hp_word  = {hp_left_pu, hp_right_pu, hp_rsvd5, hp_cm, hp_rsvd2, hp_mode, hp_short}; // R7
  assign spk_word = {spk_pu, spk_rsvd6, spk_rsvd, spk_short && spk_pu}; // R9

  // register next values
  always_comb begin
    next_page_sel    = page_sel;
    next_pol_hp      = pol_hp;
    next_pol_spk     = pol_spk;
    next_pol_rsvd    = pol_rsvd;
    next_hp_left_pu  = hp_left_pu;
    next_hp_right_pu = hp_right_pu;
    next_hp_rsvd5    = hp_rsvd5;
    next_hp_cm       = hp_cm;
    next_hp_rsvd2    = hp_rsvd2;
    next_hp_mode     = hp_mode;
    next_spk_pu      = spk_pu;
    next_spk_rsvd6   = spk_rsvd6;
    next_spk_rsvd    = spk_rsvd;
    // page select sits at location 0 of every page
    if (reg_wr_i && (reg_addr_i == ADDR_PAGE_SEL)) begin
      next_page_sel = reg_wdata_i; // R15
    end
    if (wr_pol) begin
      next_pol_rsvd = reg_wdata_i[DATA_W-1:POL_RSVD_LSB]; // R14
      next_pol_hp   = reg_wdata_i[POL_HP_BIT];
      next_pol_spk  = reg_wdata_i[POL_SPK_BIT];
    end
    if (wr_hp) begin
      next_hp_left_pu  = reg_wdata_i[HP_LEFT_BIT]; // R3
      next_hp_right_pu = reg_wdata_i[HP_RIGHT_BIT]; // R4
      next_hp_rsvd5    = reg_wdata_i[HP_RSVD5_BIT];
      next_hp_cm       = reg_wdata_i[HP_CM_MSB:HP_CM_LSB]; // R5
      next_hp_rsvd2    = reg_wdata_i[HP_RSVD2_BIT]; // R11
      next_hp_mode     = reg_wdata_i[HP_MODE_BIT]; // R6
    end
    if (wr_spk) begin
      next_spk_pu    = reg_wdata_i[SPK_PWR_BIT]; // R8
      next_spk_rsvd6 = reg_wdata_i[SPK_RSVD6_BIT];
      next_spk_rsvd  = reg_wdata_i[SPK_RSVD_MSB:SPK_RSVD_LSB]; // R10
    end
    // clears come last so they override a write in the same cycle
    if (hp_auto_clear) begin
      next_hp_left_pu  = 1'b0; // R17
      next_hp_right_pu = 1'b0; // R17
    end
    if (spk_auto_clear) begin
      next_spk_pu = 1'b0; // R17
    end
  end

  // outputs and read data
  // mode 1 gates the drivers while a short lasts, even when the keep policy holds the bits
  always_comb begin
    next_left_en  = next_hp_left_pu && !(hp_mode && hp_short); // R3 R6
    next_right_en = next_hp_right_pu && !(hp_mode && hp_short); // R4 R6
    next_limit    = hp_short && !hp_mode; // R6
    next_spk_en   = next_spk_pu; // R8
    next_rdata    = 8'h00;
    if (reg_addr_i == ADDR_PAGE_SEL) begin
      next_rdata = page_sel;
    end else if (page_hit) begin
      unique case (reg_addr_i)
        ADDR_AMP_ERR_POL:  next_rdata = pol_word;
        ADDR_HP_DRV_CTRL:  next_rdata = hp_word;
        ADDR_SPK_DRV_CTRL: next_rdata = spk_word;
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      page_sel    <= PAGE_SEL_RESET;
      pol_hp      <= 1'b0; // R14
      pol_spk     <= 1'b0; // R14
      pol_rsvd    <= POL_RSVD_RESET; // R14
      hp_left_pu  <= 1'b0; // R3
      hp_right_pu <= 1'b0; // R4
      hp_rsvd5    <= 1'b0;
      hp_cm       <= HP_CM_RESET;
      hp_rsvd2    <= HP_RSVD2_RESET; // R11
      hp_mode     <= 1'b0;
      spk_pu      <= 1'b0; // R8
      spk_rsvd6   <= 1'b0;
      spk_rsvd    <= SPK_RSVD_RESET; // R10
    end else begin
      page_sel    <= next_page_sel;
      pol_hp      <= next_pol_hp;
      pol_spk     <= next_pol_spk;
      pol_rsvd    <= next_pol_rsvd;
      hp_left_pu  <= next_hp_left_pu;
      hp_right_pu <= next_hp_right_pu;
      hp_rsvd5    <= next_hp_rsvd5;
      hp_cm       <= next_hp_cm;
      hp_rsvd2    <= next_hp_rsvd2;
      hp_mode     <= next_hp_mode;
      spk_pu      <= next_spk_pu;
      spk_rsvd6   <= next_spk_rsvd6;
      spk_rsvd    <= next_spk_rsvd;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o                 <= 8'h00;
      left_headphone_driver_en_o  <= 1'b0;
      right_headphone_driver_en_o <= 1'b0;
      hp_cm_sel_o                 <= CM_1V35;
      hp_current_limit_o          <= 1'b0;
      spk_driver_en_o             <= 1'b0;
      page_sel_o                  <= PAGE_SEL_RESET;
    end else begin
      reg_rdata_o                 <= next_rdata;
      left_headphone_driver_en_o  <= next_left_en;
      right_headphone_driver_en_o <= next_right_en;
      hp_cm_sel_o                 <= cm_sel_type'(next_hp_cm); // R5
      hp_current_limit_o          <= next_limit;
      spk_driver_en_o             <= next_spk_en;
      page_sel_o                  <= next_page_sel;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_hp_auto_clear: assert property ( // R1
    hp_short && hp_mode && !pol_hp |=> !hp_left_pu && !hp_right_pu
  ) else $error("headphone power bits not cleared on short");

  a_hp_policy_hold: assert property ( // R1
    hp_short && pol_hp && !wr_hp |=> $stable(hp_left_pu) && $stable(hp_right_pu)
  ) else $error("headphone power bits changed under keep policy");

  a_spk_auto_clear: assert property ( // R2
    spk_short && !pol_spk |=> !spk_pu && !spk_driver_en_o
  ) else $error("speaker power bit not cleared on short");

  a_spk_policy_hold: assert property ( // R2
    pol_spk && !wr_spk |=> $stable(spk_pu)
  ) else $error("speaker power bit changed under keep policy");

  a_left_write: assert property ( // R3
    wr_hp && !hp_auto_clear |=> hp_left_pu == $past(reg_wdata_i[HP_LEFT_BIT])
  ) else $error("left headphone bit did not take write");

  a_right_drive: assert property ( // R4
    hp_right_pu && !hp_mode && !wr_hp |=> right_headphone_driver_en_o
  ) else $error("right headphone driver not enabled");

  a_cm_follow: assert property ( // R5
    wr_hp |=> hp_cm_sel_o == cm_sel_type'($past(reg_wdata_i[HP_CM_MSB:HP_CM_LSB]))
  ) else $error("common-mode output does not follow write");

  a_limit_mode: assert property ( // R6
    hp_short && !hp_mode && !wr_hp |=> hp_current_limit_o && !hp_auto_clear
  ) else $error("current limit not applied in limit mode");

  a_hp_status_read: assert property ( // R7
    reg_addr_i == ADDR_HP_DRV_CTRL && page_hit |=> reg_rdata_o[HP_SHORT_BIT] == $past(hp_short)
  ) else $error("headphone short status mismatch");

  a_spk_status_read: assert property ( // R9
    reg_addr_i == ADDR_SPK_DRV_CTRL && page_hit && !spk_pu |=> !reg_rdata_o[SPK_SHORT_BIT]
  ) else $error("speaker status shown while powered down");

  a_page_gate: assert property ( // R15
    reg_wr_i && !page_hit && reg_addr_i != ADDR_PAGE_SEL |=> $stable(pol_word)
  ) else $error("policy register written on foreign page");

  a_sync_delay: assert property ( // R16
    $rose(hp_short) |-> $past(hp_short_det_i, 2)
  ) else $error("headphone short bypassed the synchroniser");

  a_right_write: assert property ( // R4
    wr_hp && !hp_auto_clear |=> hp_right_pu == $past(reg_wdata_i[HP_RIGHT_BIT])
  ) else $error("right headphone bit did not take write");

  a_spk_write: assert property ( // R8
    wr_spk && !spk_auto_clear |=> spk_pu == $past(reg_wdata_i[SPK_PWR_BIT])
  ) else $error("speaker power bit did not take write");

  a_hp_mode_gate: assert property ( // R6
    hp_short && hp_mode |=> !left_headphone_driver_en_o && !right_headphone_driver_en_o
  ) else $error("headphone drivers left on in power-down mode");

  c_foreign_page: cover property (reg_wr_i && !page_hit && reg_addr_i == ADDR_HP_DRV_CTRL);
  c_hp_clear:  cover property (hp_left_pu ##1 hp_auto_clear ##1 !hp_left_pu);
  c_spk_clear: cover property (spk_pu ##1 spk_auto_clear ##1 !spk_driver_en_o);
  c_race:      cover property (wr_hp && reg_wdata_i[HP_LEFT_BIT] && hp_auto_clear);
  c_limit:     cover property (hp_current_limit_o);
endmodule
`default_nettype wire

//--- rtl/out_drv_pkg.sv
// constants for the output driver power and short-circuit control registers
`default_nettype none
package out_drv_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  // register locations
  localparam logic [6:0] ADDR_PAGE_SEL    = 7'h00;
  localparam logic [6:0] ADDR_RSVD_FIRST  = 7'h01;
  localparam logic [6:0] ADDR_RSVD_LAST   = 7'h1d;
  localparam logic [6:0] ADDR_AMP_ERR_POL = 7'h1e;
  localparam logic [6:0] ADDR_HP_DRV_CTRL = 7'h1f;
  localparam logic [6:0] ADDR_SPK_DRV_CTRL = 7'h20;

  localparam logic [7:0] PAGE_THIS        = 8'h01;
  localparam logic [7:0] PAGE_SEL_RESET   = 8'h00;

  // amplifier error policy fields
  localparam int unsigned POL_HP_BIT      = 1;
  localparam int unsigned POL_SPK_BIT     = 0;
  localparam int unsigned POL_RSVD_LSB    = 2;
  localparam logic [5:0] POL_RSVD_RESET   = 6'h00;

  // headphone driver control fields
  localparam int unsigned HP_LEFT_BIT     = 7;
  localparam int unsigned HP_RIGHT_BIT    = 6;
  localparam int unsigned HP_RSVD5_BIT    = 5;
  localparam int unsigned HP_CM_MSB       = 4;
  localparam int unsigned HP_CM_LSB       = 3;
  localparam int unsigned HP_RSVD2_BIT    = 2;
  localparam int unsigned HP_MODE_BIT     = 1;
  localparam int unsigned HP_SHORT_BIT    = 0;
  localparam logic [1:0] HP_CM_RESET      = 2'h0;
  localparam logic       HP_RSVD2_RESET   = 1'b1;

  // common-mode codes: 1.35 V, 1.5 V, 1.65 V, 1.8 V
  typedef enum logic [1:0] {
    CM_1V35 = 2'h0,
    CM_1V50 = 2'h1,
    CM_1V65 = 2'h2,
    CM_1V80 = 2'h3
  } cm_sel_type;

  // speaker driver control fields
  localparam int unsigned SPK_PWR_BIT     = 7;
  localparam int unsigned SPK_RSVD6_BIT   = 6;
  localparam int unsigned SPK_RSVD_MSB    = 5;
  localparam int unsigned SPK_RSVD_LSB    = 1;
  localparam int unsigned SPK_SHORT_BIT   = 0;
  localparam logic [4:0] SPK_RSVD_RESET   = 5'h03;

  localparam int unsigned SYNC_W          = 2;
endpackage
`default_nettype wire

//--- rtl/sync_two_ff.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none
module sync_two_ff #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage_one <= '0;
      sync_o    <= '0;
    end else begin
      stage_one <= async_i;
      sync_o    <= stage_one;
    end
  end
endmodule
`default_nettype wire

//--- verification/host_model.sv
// host controller model driving the register port of the driver control bank
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock
  input  wire logic       clk_i,
  // register port
  output var  logic       reg_wr_o,
  output var  logic [6:0] reg_addr_o,
  output var  logic [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_addr_o = 7'h00;
    reg_wdata_o = 8'h00;
  end
  // write one register; reserved fields are forced to their allowed values
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 7'h1f) v = {v[7:6], 1'b0, v[4:3], 1'b1, v[1:0]};
    if (a == 7'h20) v = {v[7:6], 5'h03, v[0]};
    if (a >= 7'h01 && a <= 7'h1d) return;
    @(posedge clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= v;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    // return at the falling edge so outputs launched by the write have settled
    @(negedge clk_i);
  endtask
  // read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    @(posedge clk_i);
    @(negedge clk_i);
    d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking testbench for the output driver power and short-circuit bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import out_drv_pkg::*;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       reg_wr;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       hp_short = 1'b0;
  logic       spk_short = 1'b0;
  logic       hpl_en;
  logic       hpr_en;
  cm_sel_type cm_sel;
  logic       hp_limit;
  logic       spk_en;
  logic [7:0] page_sel;
  int         num_errors = 0;
  int         compares = 0;
  int         cycles = 0;

  always #50 clk = ~clk;

  host_model HOST (
    .clk_i       (clk),
    .reg_wr_o    (reg_wr),
    .reg_addr_o  (reg_addr),
    .reg_wdata_o (reg_wdata),
    .reg_rdata_i (reg_rdata)
  );

  output_driver_power_short_ctrl DUT (
    .clk_i                       (clk),
    .resetn_i                    (resetn),
    .reg_wr_i                    (reg_wr),
    .reg_addr_i                  (reg_addr),
    .reg_wdata_i                 (reg_wdata),
    .reg_rdata_o                 (reg_rdata),
    .hp_short_det_i              (hp_short),
    .spk_short_det_i             (spk_short),
    .left_headphone_driver_en_o  (hpl_en),
    .right_headphone_driver_en_o (hpr_en),
    .hp_cm_sel_o                 (cm_sel),
    .hp_current_limit_o          (hp_limit),
    .spk_driver_en_o             (spk_en),
    .page_sel_o                  (page_sel)
  );

  task automatic end_of_test;
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    HOST.rd(a, d);
    check(d, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic t_reset;
    rdchk(7'h00, 8'h00);
    rdchk(7'h1f, 8'h00);
    HOST.wr(7'h00, 8'h01);
    check(page_sel, 8'h01);
    rdchk(7'h1e, 8'h00);
    rdchk(7'h1f, 8'h04);
    rdchk(7'h20, 8'h06);
    rdchk(7'h05, 8'h00);
    check({5'h00, hpl_en, hpr_en, spk_en}, 8'h00);
  endtask

  task automatic t_cm;
    for (int i = 0; i < 4; i++) begin
      HOST.wr(7'h1f, 8'hc4 | 8'(i << 3));
      rdchk(7'h1f, 8'hc4 | 8'(i << 3));
      check({6'h00, cm_sel}, 8'(i));
      check({6'h00, hpl_en, hpr_en}, 8'h03);
    end
    HOST.wr(7'h1f, 8'h04);
    rdchk(7'h1f, 8'h04);
    check({6'h00, hpl_en, hpr_en}, 8'h00);
  endtask

  // every policy and mode pair of the headphone short reaction
  task automatic t_hp_short;
    logic clr;
    for (int k = 0; k < 4; k++) begin
      clr = (k == 1);
      HOST.wr(7'h1e, {6'h00, k[1], 1'b0});
      HOST.wr(7'h1f, 8'hc4 | {6'h00, k[0], 1'b0});
      @(posedge clk);
      hp_short <= 1'b1;
      settle(6);
      rdchk(7'h1f, (clr ? 8'h04 : 8'hc4) | {6'h00, k[0], 1'b0} | 8'h01);
      check({6'h00, hpl_en, hpr_en}, k[0] ? 8'h00 : 8'h03);
      check({7'h00, hp_limit}, {7'h00, ~k[0]});
      @(posedge clk);
      hp_short <= 1'b0;
      settle(4);
    end
  endtask

  task automatic t_spk;
    for (int p = 0; p < 2; p++) begin
      HOST.wr(7'h1e, 8'(p));
      HOST.wr(7'h20, 8'h86);
      @(posedge clk);
      spk_short <= 1'b1;
      settle(6);
      rdchk(7'h20, p ? 8'h87 : 8'h06);
      check({7'h00, spk_en}, 8'(p));
      @(posedge clk);
      spk_short <= 1'b0;
      settle(4);
    end
  endtask

  task automatic t_priority;
    HOST.wr(7'h1e, 8'h00);
    @(posedge clk);
    hp_short <= 1'b1;
    settle(6);
    HOST.wr(7'h1f, 8'hc6);
    rdchk(7'h1f, 8'h07);
    @(posedge clk);
    hp_short <= 1'b0;
    settle(4);
    rdchk(7'h1f, 8'h06);
  endtask

  task automatic t_page;
    HOST.wr(7'h00, 8'h02);
    HOST.wr(7'h1f, 8'hc4);
    rdchk(7'h1f, 8'h00);
    rdchk(7'h00, 8'h02);
    HOST.wr(7'h00, 8'h01);
    rdchk(7'h1f, 8'h06);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    settle(2);
    resetn <= 1'b1;
    t_reset();
    t_cm();
    t_hp_short();
    t_spk();
    t_priority();
    t_page();
    end_of_test();
  end
endmodule
`default_nettype wire
